// ### common/ocd_pkg.sv
// Constants and types for the opcode decoder and wait/stop power control.
// Assumes one clock domain; the sequencer consumes decode results combinationally.
//
// Function
// - 0x00-0x0F bit-test-branch 3 bytes 5 cycles; 0x10-0x1F bit set/clear 2 bytes 5 cycles.
// - 0x20-0x2F relative branches, 2 bytes 3 cycles, low nibble is condition.
// - Columns 3-7 read-modify-write, operation chosen by low nibble.
// - RMW timing: page-zero 2/5, register 1/3, byte-offset 2/6, zero-offset 1/5; test (low nibble D) one cycle less except register.
// - 0x42 is one-byte unsigned 8x8 multiply taking 11 cycles.
// - 0x80,0x81,0x83,0x8E,0x8F: interrupt return, return, software interrupt, stop, wait.
// - 0x97-0x9D and 0x9F: one-byte two-cycle register and flag operations; 0x9E is unassigned.
// - Columns A-F share one operation per low nibble.
// - Arithmetic/load forms: 2/2, 2/3, 3/4, 3/5, 2/4, 1/3 bytes/cycles.
// - Stores lack immediate form; memory forms take 4, 5, 6, 5, 4 cycles.
// - 0xAD branch to subroutine 2/6; subroutine jump and jump cycle tables.
// - Wait halts the CPU clock; timer, serial units and watchdog keep running.
// - Wait ends on timer, serial, SPI, pin interrupt or watchdog/pin reset.
// - Timer runs during wait always; serial units may be disabled by software.
// - Interrupt exit from wait leaves peripheral state unchanged.
// - Reset exit from wait returns peripherals to disabled reset state.
// - Stop halts oscillator and all units; wakes on low interrupt pin or pin reset.

package ocd_pkg;

  typedef enum logic [4:0] {
    OCD_ILLEGAL, OCD_BRANCH_IF_BIT_SET, OCD_BRANCH_IF_BIT_CLEAR, OCD_SET_MEMORY_BIT,
    OCD_CLEAR_MEMORY_BIT, OCD_BRANCH, OCD_RMW, OCD_UNSIGNED_PRODUCT,
    OCD_RETURN_FROM_INTERRUPT, OCD_RETURN_FROM_SUB, OCD_SOFTWARE_INTERRUPT, OCD_STOP, OCD_WAIT,
    OCD_COPY_ACC_TO_INDEX, OCD_CLEAR_CARRY, OCD_SET_CARRY, OCD_CLEAR_IRQ_MASK,
    OCD_SET_IRQ_MASK, OCD_RESET_STACK_POINTER, OCD_NOP, OCD_COPY_INDEX_TO_ACC, OCD_ALU,
    OCD_BRANCH_TO_SUBROUTINE
  } ocd_class_t;

  typedef enum logic [3:0] {
    OCD_NO_OPERAND_FORM, OCD_LITERAL_OPERAND_FORM, OCD_PAGE_ZERO_FORM, OCD_FULL_ADDRESS_FORM,
    OCD_WORD_OFFSET_INDEXED, OCD_BYTE_OFFSET_INDEXED, OCD_ZERO_OFFSET_INDEXED,
    OCD_PC_OFFSET_FORM, OCD_BIT_TEST_BRANCH_FORM, OCD_BIT_MODIFY_FORM, OCD_ACC_FORM,
    OCD_INDEX_FORM
  } ocd_form_t;

  // Low nibble operation codes shared by the register/memory columns
  localparam logic [3:0] OCD_OP_STORE_ACC = 4'h7;
  localparam logic [3:0] OCD_OP_JUMP = 4'hC;
  localparam logic [3:0] OCD_OP_JSR = 4'hD;
  localparam logic [3:0] OCD_OP_STORE_INDEX = 4'hF;
  localparam logic [3:0] OCD_OP_TEST = 4'hD;

  // Cycle counts
  localparam logic [3:0] OCD_CYC_BIT = 4'h5;
  localparam logic [3:0] OCD_CYC_BRANCH = 4'h3;
  localparam logic [3:0] OCD_CYC_MUL = 4'hB;
  localparam logic [3:0] OCD_CYC_RTI = 4'h9;
  localparam logic [3:0] OCD_CYC_RTS = 4'h6;
  localparam logic [3:0] OCD_CYC_SWI = 4'hA;
  localparam logic [3:0] OCD_CYC_SHORT = 4'h2;
  localparam logic [3:0] OCD_CYC_BSR = 4'h6;
  localparam logic [3:0] OCD_CYC_RMW_DIR = 4'h5;
  localparam logic [3:0] OCD_CYC_RMW_REG = 4'h3;
  localparam logic [3:0] OCD_CYC_RMW_IX1 = 4'h6;
  localparam logic [3:0] OCD_CYC_RMW_IX = 4'h5;
  // Column A..F base cycles for plain arithmetic/load, index by column-0xA
  localparam logic [23:0] OCD_CYC_ALU_TAB = {4'h3, 4'h4, 4'h5, 4'h4, 4'h3, 4'h2};
  localparam logic [23:0] OCD_CYC_STORE_TAB = {4'h4, 4'h5, 4'h6, 4'h5, 4'h4, 4'h0};
  localparam logic [23:0] OCD_CYC_JMP_TAB = {4'h2, 4'h3, 4'h4, 4'h3, 4'h2, 4'h0};
  localparam logic [23:0] OCD_CYC_JSR_TAB = {4'h5, 4'h6, 4'h7, 4'h6, 4'h5, 4'h6};
  localparam logic [11:0] OCD_LEN_TAB = {2'd1, 2'd2, 2'd3, 2'd3, 2'd2, 2'd2};

  // Power state after reset
  typedef enum logic [1:0] {OCD_RUN, OCD_WAITING, OCD_STOPPED} ocd_pwr_t;

endpackage

// ### hw/ocd_decode.sv
`timescale 1ns/1ps
// Pure combinational opcode decoder.
// Assumes opcode is stable for the cycle it is fetched.
module ocd_decode (
  input wire logic [7:0] opcode,
  output ocd_pkg::ocd_class_t op_class,
  output ocd_pkg::ocd_form_t op_form,
  output logic [3:0] op_sub,
  output logic [1:0] op_len,
  output logic [3:0] op_cycles,
  output logic op_illegal
);
  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];
  wire [2:0] col = 3'(hi - 4'hA);
  wire rmw_hole = (lo == 4'h1) || (lo == 4'h2) || (lo == 4'h5) || (lo == 4'hB) || (lo == 4'hE);
  wire [3:0] alu_cyc = ocd_pkg::OCD_CYC_ALU_TAB[col*4 +: 4];
  wire [3:0] sto_cyc = ocd_pkg::OCD_CYC_STORE_TAB[col*4 +: 4];
  wire [3:0] jmp_cyc = ocd_pkg::OCD_CYC_JMP_TAB[col*4 +: 4];
  wire [3:0] jsr_cyc = ocd_pkg::OCD_CYC_JSR_TAB[col*4 +: 4];
  wire [1:0] col_len = ocd_pkg::OCD_LEN_TAB[col*2 +: 2];
  wire [3:0] test_adj = (lo == ocd_pkg::OCD_OP_TEST) ? 4'h1 : 4'h0;

  assign op_illegal = (op_class == ocd_pkg::OCD_ILLEGAL);

  always_comb
  begin
    op_class = ocd_pkg::OCD_ILLEGAL;
    op_form = ocd_pkg::OCD_NO_OPERAND_FORM;
    op_sub = lo;
    op_len = 2'd1;
    op_cycles = 4'h0;
    case (hi)
      4'h0:
      begin
        op_class = lo[0] ? ocd_pkg::OCD_BRANCH_IF_BIT_CLEAR : ocd_pkg::OCD_BRANCH_IF_BIT_SET;
        op_form = ocd_pkg::OCD_BIT_TEST_BRANCH_FORM;
        op_sub = {1'b0, lo[3:1]};
        op_len = 2'd3;
        op_cycles = ocd_pkg::OCD_CYC_BIT;
      end
      4'h1:
      begin
        op_class = lo[0] ? ocd_pkg::OCD_CLEAR_MEMORY_BIT : ocd_pkg::OCD_SET_MEMORY_BIT;
        op_form = ocd_pkg::OCD_BIT_MODIFY_FORM;
        op_sub = {1'b0, lo[3:1]};
        op_len = 2'd2;
        op_cycles = ocd_pkg::OCD_CYC_BIT;
      end
      4'h2:
      begin
        op_class = ocd_pkg::OCD_BRANCH;
        op_form = ocd_pkg::OCD_PC_OFFSET_FORM;
        op_len = 2'd2;
        op_cycles = ocd_pkg::OCD_CYC_BRANCH;
      end
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
      begin
        if (opcode == 8'h42)
        begin
          op_class = ocd_pkg::OCD_UNSIGNED_PRODUCT;
          op_cycles = ocd_pkg::OCD_CYC_MUL;
        end
        else if (!rmw_hole)
        begin
          op_class = ocd_pkg::OCD_RMW;
          case (hi)
            4'h3:
            begin
              op_form = ocd_pkg::OCD_PAGE_ZERO_FORM;
              op_len = 2'd2;
              op_cycles = 4'(ocd_pkg::OCD_CYC_RMW_DIR - test_adj);
            end
            4'h4:
            begin
              op_form = ocd_pkg::OCD_ACC_FORM;
              op_cycles = ocd_pkg::OCD_CYC_RMW_REG;
            end
            4'h5:
            begin
              op_form = ocd_pkg::OCD_INDEX_FORM;
              op_cycles = ocd_pkg::OCD_CYC_RMW_REG;
            end
            4'h6:
            begin
              op_form = ocd_pkg::OCD_BYTE_OFFSET_INDEXED;
              op_len = 2'd2;
              op_cycles = 4'(ocd_pkg::OCD_CYC_RMW_IX1 - test_adj);
            end
            default:
            begin
              op_form = ocd_pkg::OCD_ZERO_OFFSET_INDEXED;
              op_cycles = 4'(ocd_pkg::OCD_CYC_RMW_IX - test_adj);
            end
          endcase
        end
      end
      4'h8:
      begin
        op_cycles = ocd_pkg::OCD_CYC_SHORT;
        case (lo)
          4'h0:
          begin
            op_class = ocd_pkg::OCD_RETURN_FROM_INTERRUPT;
            op_cycles = ocd_pkg::OCD_CYC_RTI;
          end
          4'h1:
          begin
            op_class = ocd_pkg::OCD_RETURN_FROM_SUB;
            op_cycles = ocd_pkg::OCD_CYC_RTS;
          end
          4'h3:
          begin
            op_class = ocd_pkg::OCD_SOFTWARE_INTERRUPT;
            op_cycles = ocd_pkg::OCD_CYC_SWI;
          end
          4'hE: op_class = ocd_pkg::OCD_STOP;
          4'hF: op_class = ocd_pkg::OCD_WAIT;
          default: op_cycles = 4'h0;
        endcase
      end
      4'h9:
      begin
        op_cycles = ocd_pkg::OCD_CYC_SHORT;
        case (lo)
          4'h7: op_class = ocd_pkg::OCD_COPY_ACC_TO_INDEX;
          4'h8: op_class = ocd_pkg::OCD_CLEAR_CARRY;
          4'h9: op_class = ocd_pkg::OCD_SET_CARRY;
          4'hA: op_class = ocd_pkg::OCD_CLEAR_IRQ_MASK;
          4'hB: op_class = ocd_pkg::OCD_SET_IRQ_MASK;
          4'hC: op_class = ocd_pkg::OCD_RESET_STACK_POINTER;
          4'hD: op_class = ocd_pkg::OCD_NOP;
          4'hF: op_class = ocd_pkg::OCD_COPY_INDEX_TO_ACC;
          default: op_cycles = 4'h0;
        endcase
      end
      default:
      begin
        op_class = ocd_pkg::OCD_ALU;
        op_form = ocd_pkg::ocd_form_t'(4'(col) + 4'd1);
        if (col == 3'd5)
          op_form = ocd_pkg::OCD_ZERO_OFFSET_INDEXED;
        op_len = col_len;
        op_cycles = alu_cyc;
        if (lo == ocd_pkg::OCD_OP_STORE_ACC || lo == ocd_pkg::OCD_OP_STORE_INDEX)
          op_cycles = sto_cyc;
        else if (lo == ocd_pkg::OCD_OP_JUMP)
          op_cycles = jmp_cyc;
        else if (lo == ocd_pkg::OCD_OP_JSR)
          op_cycles = jsr_cyc;
        if (col == 3'd0 && lo == ocd_pkg::OCD_OP_JSR)
        begin
          op_class = ocd_pkg::OCD_BRANCH_TO_SUBROUTINE;
          op_form = ocd_pkg::OCD_PC_OFFSET_FORM;
        end
        if (op_cycles == 4'h0)
          op_class = ocd_pkg::OCD_ILLEGAL;
      end
    endcase
    if (op_class == ocd_pkg::OCD_ILLEGAL)
    begin
      op_form = ocd_pkg::OCD_NO_OPERAND_FORM;
      op_len = 2'd1;
      op_cycles = 4'h0;
    end
  end
endmodule

// ### hw/ocd_core.sv
`timescale 1ns/1ps
// Top: opcode decode plus wait/stop power sequencing.
// Assumes the sequencer pulses exec_strobe when an opcode completes execution.
module ocd_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] opcode,
  input wire logic exec_strobe,
  input wire logic timer_irq,
  input wire logic serial_irq,
  input wire logic spi_irq,
  input wire logic irq_pin_n,
  input wire logic watchdog_reset,
  input wire logic reset_pin_n,
  output ocd_pkg::ocd_class_t op_class,
  output ocd_pkg::ocd_form_t op_form,
  output logic [3:0] op_sub,
  output logic [1:0] op_len,
  output logic [3:0] op_cycles,
  output logic op_illegal,
  output logic cpu_clk_en,
  output logic osc_en,
  output logic periph_run,
  output logic periph_reset,
  output logic wake_irq
);
  ocd_pkg::ocd_pwr_t pwr_r, pwr_nxt;
  logic [2:0] irqp_s_r;
  logic [2:0] rstp_s_r;
  logic periph_reset_r;
  logic wake_irq_r;

  ocd_decode u_dec (
    .opcode(opcode),
    .op_class(op_class),
    .op_form(op_form),
    .op_sub(op_sub),
    .op_len(op_len),
    .op_cycles(op_cycles),
    .op_illegal(op_illegal)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a low counts once stages two and three agree; a high counts as soon as stage two reads it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irqp_s_r <= 3'b111;
      rstp_s_r <= 3'b111;
    end
    else
    begin
      irqp_s_r <= {irqp_s_r[1:0], irq_pin_n};
      rstp_s_r <= {rstp_s_r[1:0], reset_pin_n};
    end
  end
  wire irq_low = !irqp_s_r[1] && !irqp_s_r[2];
  wire pin_reset = !rstp_s_r[1] && !rstp_s_r[2];

  ////////////////////////////////////////////////////////////////////////
  wire any_reset = watchdog_reset || pin_reset;
  // Watchdog is frozen in stop, so it must not turn a pin wake into a reset exit
  wire exit_reset = (pwr_r == ocd_pkg::OCD_STOPPED) ? pin_reset : any_reset;
  wire wait_wake = timer_irq || serial_irq || spi_irq || irq_low;
  wire go_wait = exec_strobe && (op_class == ocd_pkg::OCD_WAIT);
  wire go_stop = exec_strobe && (op_class == ocd_pkg::OCD_STOP);

  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ocd_pkg::OCD_RUN:
        if (go_wait)
          pwr_nxt = ocd_pkg::OCD_WAITING;
        else if (go_stop)
          pwr_nxt = ocd_pkg::OCD_STOPPED;
      ocd_pkg::OCD_WAITING:
        if (any_reset || wait_wake)
          pwr_nxt = ocd_pkg::OCD_RUN;
      ocd_pkg::OCD_STOPPED:
        // Watchdog is halted in stop, so only the pin interrupt or pin reset wakes
        if (irq_low || pin_reset)
          pwr_nxt = ocd_pkg::OCD_RUN;
      default: pwr_nxt = ocd_pkg::OCD_RUN;
    endcase
    if (pwr_r != ocd_pkg::OCD_STOPPED && any_reset)
      pwr_nxt = ocd_pkg::OCD_RUN;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwr_r <= ocd_pkg::OCD_RUN;
      periph_reset_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      // Reset exit disables peripherals; interrupt exit leaves them alone
      periph_reset_r <= exit_reset;
      wake_irq_r <= (pwr_r != ocd_pkg::OCD_RUN) && (pwr_nxt == ocd_pkg::OCD_RUN)
        && !exit_reset;
    end
  end

  assign cpu_clk_en = (pwr_r == ocd_pkg::OCD_RUN);
  assign osc_en = (pwr_r != ocd_pkg::OCD_STOPPED);
  // Timer has no off switch in wait; serial units gate themselves via their own enables
  assign periph_run = (pwr_r != ocd_pkg::OCD_STOPPED);
  assign periph_reset = periph_reset_r;
  assign wake_irq = wake_irq_r;
endmodule

// ### tb/ocd_properties.sv
// Checker for the decoder and power-state outputs of ocd_core.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module ocd_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] opcode,
  input wire logic exec_strobe,
  input wire logic timer_irq,
  input wire logic serial_irq,
  input wire logic spi_irq,
  input wire logic irq_pin_n,
  input wire logic watchdog_reset,
  input wire logic reset_pin_n,
  input wire ocd_pkg::ocd_class_t op_class,
  input wire logic [3:0] op_sub,
  input wire logic [1:0] op_len,
  input wire logic [3:0] op_cycles,
  input wire logic op_illegal,
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic periph_run,
  input wire logic periph_reset,
  input wire logic wake_irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_wait_entry:
    assert property (exec_strobe && cpu_clk_en && op_class == ocd_pkg::OCD_WAIT
      |=> !cpu_clk_en && osc_en && periph_run) else $error("wait entry wrong");
  a_stop_entry:
    assert property (exec_strobe && cpu_clk_en && op_class == ocd_pkg::OCD_STOP
      |=> !cpu_clk_en && !osc_en && !periph_run) else $error("stop entry wrong");
  a_wait_periph:
    assert property (!cpu_clk_en && osc_en |-> periph_run) else $error("units off in wait");
  a_wake_irq:
    assert property (!cpu_clk_en && osc_en && (timer_irq || serial_irq || spi_irq)
      && !watchdog_reset |=> cpu_clk_en && wake_irq && !periph_reset)
      else $error("interrupt wake wrong");
  // Pins high for four samples means the three-flop synchronisers read idle
  a_stop_hold:
    assert property ((irq_pin_n && reset_pin_n)[*4] ##0 !osc_en |=> !osc_en)
      else $error("stop left without pin");
  a_wd_reset:
    assert property (!cpu_clk_en && osc_en && watchdog_reset
      |=> cpu_clk_en && !wake_irq ##[0:1] periph_reset) else $error("reset exit wrong");
  a_illegal_op:
    assert property (op_illegal |-> op_cycles == 4'h0 && op_len == 2'd1)
      else $error("illegal opcode fields wrong");
  a_mul_decode:
    assert property (opcode == 8'h42 |-> op_class == ocd_pkg::OCD_UNSIGNED_PRODUCT
      && op_cycles == 4'hB && op_len == 2'd1) else $error("multiply decode wrong");
  a_bit_group:
    assert property (opcode[7:5] == 3'h0 |-> op_sub == {1'b0, opcode[3:1]}
      && op_cycles == 4'h5 && op_len == (opcode[4] ? 2'd2 : 2'd3))
      else $error("bit group decode wrong");
  a_branch_row:
    assert property (opcode[7:4] == 4'h2 |-> op_class == ocd_pkg::OCD_BRANCH
      && op_sub == opcode[3:0] && op_len == 2'd2 && op_cycles == 4'h3)
      else $error("branch decode wrong");
  c_wait_wake: cover property (!cpu_clk_en && osc_en ##1 wake_irq);
  c_stopped: cover property (!osc_en);
  c_reset_exit: cover property (periph_reset);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ocd_core ocd_properties u_ocd_properties (.clk_sys, .rst_n, .opcode, .exec_strobe,
  .timer_irq, .serial_irq, .spi_irq, .irq_pin_n, .watchdog_reset, .reset_pin_n, .op_class,
  .op_sub, .op_len, .op_cycles, .op_illegal, .cpu_clk_en, .osc_en, .periph_run,
  .periph_reset, .wake_irq);

// ### tb/ocd_seq_model.sv
// Sequencer stand-in: presents fetched opcodes and completion strobes.
// Assumes the bench changes its commands just after the rising edge.
`timescale 1ns/1ps
module ocd_seq_model (
  input wire logic cpu_clk_en,
  input wire logic [7:0] cmd_op,
  input wire logic cmd_go,
  output logic [7:0] opcode,
  output logic exec_strobe
);
  assign opcode = cmd_op;
  // A halted sequencer cannot complete an instruction
  assign exec_strobe = cmd_go & cpu_clk_en;
endmodule

// ### tb/ocd_core_test.sv
// Self-checking bench for ocd_core: decode tables and wait/stop exits.
// Assumes the checker is bound in and the sequencer model feeds the opcode.
`timescale 1ns/1ps
module ocd_core_test;
  typedef struct packed {logic [1:0] k; logic [7:0] e;} ocd_note_t;
  logic clk_sys, rst_n, cmd_go, timer_irq, serial_irq, spi_irq;
  logic irq_pin_n, watchdog_reset, reset_pin_n, exec_strobe, op_illegal;
  logic cpu_clk_en, osc_en, periph_run, periph_reset, wake_irq;
  logic [7:0] cmd_op, opcode;
  logic [3:0] op_sub, op_cycles;
  logic [1:0] op_len;
  ocd_pkg::ocd_class_t op_class;
  ocd_pkg::ocd_form_t op_form;
  ocd_note_t notes[$];
  ocd_note_t n;
  int fail_count, comparisons, cycles, seed;
  // Entries are opcode, length, cycles; zero cycles marks an unassigned opcode
  logic [15:0] dec_tab[] = '{16'h0035, 16'h1F25, 16'h2023, 16'h2F23, 16'h3025, 16'h3D24,
    16'h4013, 16'h4D13, 16'h5F13, 16'h6026, 16'h6D25, 16'h7015, 16'h7D14, 16'h421B,
    16'h8019, 16'h8116, 16'h831A, 16'h8F12, 16'h9712, 16'h9F12, 16'hA022, 16'hB023,
    16'hC034, 16'hD035, 16'hE024, 16'hF013, 16'hB724, 16'hC735, 16'hD736, 16'hE725,
    16'hBF24, 16'hAD26, 16'hBD25, 16'hCD36, 16'hDD37, 16'hED26, 16'hBC22, 16'hCC33,
    16'hDC34, 16'hEC23, 16'hFC12, 16'hA710, 16'hAC10, 16'h3110, 16'h4510, 16'h9E10};
  logic [7:0] cls_op[] = '{8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9F,
    8'h80, 8'h81, 8'h83, 8'h8E, 8'h8F, 8'hAD, 8'h0A, 8'h1B};
  ocd_pkg::ocd_class_t cls_exp[] = '{ocd_pkg::OCD_COPY_ACC_TO_INDEX,
    ocd_pkg::OCD_CLEAR_CARRY, ocd_pkg::OCD_SET_CARRY, ocd_pkg::OCD_CLEAR_IRQ_MASK,
    ocd_pkg::OCD_SET_IRQ_MASK, ocd_pkg::OCD_RESET_STACK_POINTER, ocd_pkg::OCD_NOP,
    ocd_pkg::OCD_COPY_INDEX_TO_ACC, ocd_pkg::OCD_RETURN_FROM_INTERRUPT,
    ocd_pkg::OCD_RETURN_FROM_SUB, ocd_pkg::OCD_SOFTWARE_INTERRUPT, ocd_pkg::OCD_STOP,
    ocd_pkg::OCD_WAIT, ocd_pkg::OCD_BRANCH_TO_SUBROUTINE,
    ocd_pkg::OCD_BRANCH_IF_BIT_SET, ocd_pkg::OCD_CLEAR_MEMORY_BIT};
  logic [7:0] frm_op[] = '{8'hA6, 8'hB6, 8'hC6, 8'hD6, 8'hE6, 8'hF6, 8'h33, 8'h43, 8'h53,
    8'h63, 8'h73, 8'h27, 8'hAD, 8'h05, 8'h18, 8'h9D, 8'hA7};
  ocd_pkg::ocd_form_t frm_exp[] = '{ocd_pkg::OCD_LITERAL_OPERAND_FORM,
    ocd_pkg::OCD_PAGE_ZERO_FORM, ocd_pkg::OCD_FULL_ADDRESS_FORM,
    ocd_pkg::OCD_WORD_OFFSET_INDEXED, ocd_pkg::OCD_BYTE_OFFSET_INDEXED,
    ocd_pkg::OCD_ZERO_OFFSET_INDEXED, ocd_pkg::OCD_PAGE_ZERO_FORM, ocd_pkg::OCD_ACC_FORM,
    ocd_pkg::OCD_INDEX_FORM, ocd_pkg::OCD_BYTE_OFFSET_INDEXED,
    ocd_pkg::OCD_ZERO_OFFSET_INDEXED, ocd_pkg::OCD_PC_OFFSET_FORM, ocd_pkg::OCD_PC_OFFSET_FORM,
    ocd_pkg::OCD_BIT_TEST_BRANCH_FORM, ocd_pkg::OCD_BIT_MODIFY_FORM,
    ocd_pkg::OCD_NO_OPERAND_FORM, ocd_pkg::OCD_NO_OPERAND_FORM};
  ocd_core u_ocd_core (.clk_sys, .rst_n, .opcode, .exec_strobe, .timer_irq, .serial_irq,
    .spi_irq, .irq_pin_n, .watchdog_reset, .reset_pin_n, .op_class, .op_form, .op_sub,
    .op_len, .op_cycles, .op_illegal, .cpu_clk_en, .osc_en, .periph_run, .periph_reset,
    .wake_irq);
  ocd_seq_model u_ocd_seq_model (.cpu_clk_en, .cmd_op, .cmd_go, .opcode, .exec_strobe);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic want(input logic [1:0] k, input logic [7:0] e);
    notes.push_back('{k, e});
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic enter(input logic [7:0] op, input logic [7:0] exp);
    cmd_op = op;
    cmd_go = 1;
    tick();
    cmd_go = 0;
    cmd_op = 8'h9D;
    want(2, exp);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Decode is combinational and power state settles at the edge, so mid-cycle is safe
  always @(negedge clk_sys)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.k)
        2'd0: check({1'b0, op_len, op_cycles, op_illegal}, n.e);
        2'd1: check({3'h0, op_class}, n.e);
        2'd3: check({4'h0, op_form}, n.e);
        default: check({3'h0, cpu_clk_en, osc_en, periph_run, periph_reset, wake_irq}, n.e);
      endcase
    end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      complete_run();
    end
  end
  initial
  begin
    seed = 65;
    rst_n = 0;
    cmd_op = 8'h9D;
    cmd_go = 0;
    {spi_irq, serial_irq, timer_irq} = 3'h0;
    irq_pin_n = 1;
    watchdog_reset = 0;
    reset_pin_n = 1;
    repeat (5) tick();
    rst_n = 1;
    tick();
    want(2, 8'h1C);
    foreach (dec_tab[i])
    begin
      cmd_op = dec_tab[i][15:8];
      want(0, {1'b0, dec_tab[i][5:4], dec_tab[i][3:0], dec_tab[i][3:0] == 4'h0});
      tick();
    end
    foreach (cls_op[i])
    begin
      cmd_op = cls_op[i];
      want(1, {3'h0, cls_exp[i]});
      tick();
    end
    foreach (frm_op[i])
    begin
      cmd_op = frm_op[i];
      want(3, {4'h0, frm_exp[i]});
      tick();
    end
    repeat (6)
    begin
      enter(8'h8F, 8'h0C);
      repeat ($unsigned($random(seed)) % 3)
      begin
        tick();
        want(2, 8'h0C);
      end
      {spi_irq, serial_irq, timer_irq} = 3'h1 << ($unsigned($random(seed)) % 3);
      tick();
      want(2, 8'h1D);
      {spi_irq, serial_irq, timer_irq} = 3'h0;
      tick();
      want(2, 8'h1C);
    end
    enter(8'h8F, 8'h0C);
    watchdog_reset = 1;
    repeat (2) tick();
    want(2, 8'h1E);
    watchdog_reset = 0;
    repeat (2) tick();
    enter(8'h8F, 8'h0C);
    reset_pin_n = 0;
    repeat (5) tick();
    want(2, 8'h1E);
    reset_pin_n = 1;
    repeat (6) tick();
    want(2, 8'h1C);
    enter(8'h8E, 8'h00);
    {spi_irq, serial_irq, timer_irq} = 3'h7;
    watchdog_reset = 1;
    repeat (3) tick();
    want(2, 8'h00);
    {spi_irq, serial_irq, timer_irq} = 3'h0;
    watchdog_reset = 0;
    irq_pin_n = 0;
    repeat (4) tick();
    want(2, 8'h1D);
    repeat (2) tick();
    want(2, 8'h1C);
    irq_pin_n = 1;
    enter(8'h8F, 8'h0C);
    rst_n = 0;
    tick();
    want(2, 8'h1C);
    rst_n = 1;
    repeat (2) tick();
    complete_run();
  end
endmodule
